/* hw/disk_err_defines.svh */
// bit positions, reset values and timing figures for the disk error/status block
// assumes inclusion by bare name from the block's design file
`ifndef DISK_ERR_DEFINES_SVH
`define DISK_ERR_DEFINES_SVH
// controller status word, host bit numbers (bit 0 = msb)
`define CS_DONE 1
`define CS_CYL 10
`define CS_SURF 11
`define CS_VERIFY 12
`define CS_TIMEOUT 13
`define CS_LATE 14
`define CS_ERROR 15
// drive status word, host bit numbers
`define DS_RELEASED 0
`define DS_RESERVED 1
`define DS_READY 3
`define DS_BUSY 4
`define DS_WPROT 6
`define DS_ILL_ADDR 8
`define DS_ILL_CMD 9
`define DS_FAULT_LO 10
`define DS_FAULT_HI 12
`define DS_ERROR 15
// timing
`define CLK_KHZ 40000
`define XFER_TIMEOUT_MS 1000
`define SEEK_TIMEOUT_MS 500
// reset value of the single read-back register that carries both status words
`define STATUS_RESET 16'h0000
`endif

/* hw/disk_err_pkg.sv */
// types shared by the disk error/status block
// assumes nothing beyond a SystemVerilog compiler
package disk_err_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_XFER = 3'b010,
        ST_TAIL = 3'b100
    } xfer_state_e;
endpackage

/* hw/disk_err_status.sv */
// error and status logic of a multi-drive disk controller on a programmed-i/o bus
// assumes device-code decode outside; drive pins are asynchronous, datapath events on clk
// Function
// - heads off seek cylinder: set bit 10, abort, counters stay on sector
// - header surface differs from loaded surface: set bit 11, abort at once
// - verify mismatch sets bit 12, sector finishes, then error and done
// - transfer not done within one second: set bit 13, abort at once
// - fifo over/underflow sets bit 14 and aborts immediately
// - controller bit 15 is any controller error or selected drive error
// - read drive status returns flags of drive picked by last buffer-a output
// - drive bit 0 shows released, bit 1 reserved by other controller
// - drive bit 3 ready, bit 4 positioning, bit 6 write disabled
// - drive bits 2, 5, 7, 13, 14 always read zero
// - bit 8 on cylinder too large or seek over 500 ms; auto recalibrate
// - bit 9 on seek to busy drive or write to protected drive
// - fault on selected drive during transfer ends it with done and error
// - every detected drive fault sends a fault-clear command to that drive
// - drive seek error sends recalibrate and sets that drive's done flag
// - multifunction variant: fault on bit 12 only; disk-only: bits 10-12
// - drive bit 15 is the or of illegal address, illegal command and fault
// - start clears controller errors and restarts the transfer timeout
// - clear aborts the transfer, clears errors and drive attention flags
// - controller status bit 1 mirrors the read/write done flag
`include "disk_err_defines.svh"

module disk_err_status #(
    parameter int NUM_DRIVES = 4,
    parameter int MULTIFUNCTION = 0,
    parameter logic [15:0] MAX_CYL = 16'h0332,
    parameter int XFER_TIMEOUT_CYC = `XFER_TIMEOUT_MS * `CLK_KHZ,
    parameter int SEEK_TIMEOUT_CYC = `SEEK_TIMEOUT_MS * `CLK_KHZ,
    localparam int DRV_W = (NUM_DRIVES > 1) ? $clog2(NUM_DRIVES) : 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic input_from_buffer_a,
    input wire logic input_from_buffer_b,
    input wire logic output_to_buffer_a,
    input wire logic [15:0] bus_in,
    input wire logic start_fn,
    input wire logic clear_fn,
    input wire logic xfer_complete,
    input wire logic sector_end,
    input wire logic cyl_mismatch,
    input wire logic surf_mismatch,
    input wire logic verify_mismatch,
    input wire logic fifo_late,
    input wire logic seek_issue,
    input wire logic [15:0] seek_cyl,
    input wire logic write_issue,
    input wire logic [NUM_DRIVES-1:0] drv_released,
    input wire logic [NUM_DRIVES-1:0] drv_reserved,
    input wire logic [NUM_DRIVES-1:0] drv_ready,
    input wire logic [NUM_DRIVES-1:0] drv_busy,
    input wire logic [NUM_DRIVES-1:0] drv_wprot,
    input wire logic [NUM_DRIVES-1:0] drv_fault,
    input wire logic [NUM_DRIVES-1:0] drv_seek_err,
    input wire logic [NUM_DRIVES-1:0] drv_seek_done,
    output logic [15:0] status_data,
    output logic status_valid,
    output logic xfer_busy,
    output logic xfer_done,
    output logic abort_xfer,
    output logic [NUM_DRIVES-1:0] recal_req,
    output logic [NUM_DRIVES-1:0] fault_clear_req,
    output logic [NUM_DRIVES-1:0] drive_done_set
);

    // ==========================================================
    // helpers
    // ==========================================================
    // host numbering puts bit 0 at the msb, so every word is flipped once here
    function automatic logic [15:0] to_acc(input logic [15:0] host);
        logic [15:0] acc;
        acc = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            acc[15-i] = host[i];
        end
        return acc;
    endfunction

    // ==========================================================
    // drive pin synchronisers
    // ==========================================================
    localparam int NP = 8;
    logic [NP*NUM_DRIVES-1:0] pin_meta_reg;
    logic [NP*NUM_DRIVES-1:0] pin_sync_reg;
    logic [NUM_DRIVES-1:0] s_rel, s_res, s_rdy, s_busy, s_wp, s_flt, s_serr, s_sdone;
    logic [NUM_DRIVES-1:0] flt_prev_reg, serr_prev_reg;

    // two stages; only the second stage feeds logic
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= {drv_released, drv_reserved, drv_ready, drv_busy,
                             drv_wprot, drv_fault, drv_seek_err, drv_seek_done};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign {s_rel, s_res, s_rdy, s_busy, s_wp, s_flt, s_serr, s_sdone} = pin_sync_reg;

    // edge memory for fault and seek-error detection
    always_ff @(posedge clk) begin
        if (rst) begin
            flt_prev_reg <= '0;
            serr_prev_reg <= '0;
        end else begin
            flt_prev_reg <= s_flt;
            serr_prev_reg <= s_serr;
        end
    end

    // ==========================================================
    // drive selection
    // ==========================================================
    logic [DRV_W-1:0] sel_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            sel_reg <= '0;
        end else if (output_to_buffer_a) begin
            sel_reg <= bus_in[DRV_W-1:0];
        end
    end

    // ==========================================================
    // per-drive illegal address / command flags and seek watchdog
    // ==========================================================
    logic [NUM_DRIVES-1:0] ill_addr_reg, ill_cmd_reg, seek_pend_reg;
    logic [31:0] seek_cnt_reg [NUM_DRIVES];
    logic [NUM_DRIVES-1:0] seek_tmo, seek_bad_cyl, seek_to_busy, write_to_wp;

    always_comb begin
        for (int d = 0; d < NUM_DRIVES; d++) begin
            seek_tmo[d] = seek_pend_reg[d] && (seek_cnt_reg[d] == 32'(SEEK_TIMEOUT_CYC - 1));
            seek_bad_cyl[d] = seek_issue && (sel_reg == DRV_W'(d)) && (seek_cyl > MAX_CYL);
            seek_to_busy[d] = seek_issue && (sel_reg == DRV_W'(d)) && s_busy[d];
            write_to_wp[d] = write_issue && (sel_reg == DRV_W'(d)) && s_wp[d];
        end
    end

    // seek watchdog; a seek that is refused starts no timer
    always_ff @(posedge clk) begin
        if (rst) begin
            seek_pend_reg <= '0;
            for (int d = 0; d < NUM_DRIVES; d++) begin
                seek_cnt_reg[d] <= 32'h0000_0000;
            end
        end else begin
            for (int d = 0; d < NUM_DRIVES; d++) begin
                if (seek_issue && sel_reg == DRV_W'(d)
                    && !seek_bad_cyl[d] && !seek_to_busy[d]) begin
                    seek_pend_reg[d] <= 1'b1;
                    seek_cnt_reg[d] <= 32'h0000_0000;
                end else if (s_sdone[d] || seek_tmo[d]) begin
                    seek_pend_reg[d] <= 1'b0;
                end else if (seek_pend_reg[d]) begin
                    seek_cnt_reg[d] <= seek_cnt_reg[d] + 32'h0000_0001;
                end
            end
        end
    end

    // illegal address flag; illegal command flag
    // attention flags drop on clear, but a same-cycle event still sets them
    always_ff @(posedge clk) begin
        if (rst) begin
            ill_addr_reg <= '0;
            ill_cmd_reg <= '0;
        end else begin
            ill_addr_reg <= (clear_fn ? '0 : ill_addr_reg) | seek_bad_cyl | seek_tmo;
            ill_cmd_reg <= (clear_fn ? '0 : ill_cmd_reg) | seek_to_busy | write_to_wp;
        end
    end

    // ==========================================================
    // automatic drive recovery commands
    // ==========================================================
    // recalibrate on illegal address; recalibrate on seek error
    always_ff @(posedge clk) begin
        if (rst) begin
            recal_req <= '0;
            drive_done_set <= '0;
        end else begin
            recal_req <= seek_bad_cyl | seek_tmo | (s_serr & ~serr_prev_reg);
            drive_done_set <= s_serr & ~serr_prev_reg;
        end
    end

    // fault clear on each new fault
    always_ff @(posedge clk) begin
        if (rst) begin
            fault_clear_req <= '0;
        end else begin
            fault_clear_req <= s_flt & ~flt_prev_reg;
        end
    end

    // ==========================================================
    // transfer sequencing and controller error flags
    // ==========================================================
    disk_err_pkg::xfer_state_e state_reg;
    logic err_cyl_reg, err_surf_reg, err_ver_reg, err_tmo_reg, err_late_reg;
    logic [31:0] xfer_cnt_reg;
    logic in_xfer, tmo_hit, sel_fault, kill_now, tail_end;

    assign in_xfer = (state_reg != disk_err_pkg::ST_IDLE) && !start_fn && !clear_fn;
    assign tmo_hit = in_xfer && (xfer_cnt_reg == 32'(XFER_TIMEOUT_CYC - 1));
    assign sel_fault = s_flt[sel_reg];
    // prompt terminations leave the counters where the failure happened
    assign kill_now = in_xfer && (cyl_mismatch || surf_mismatch || tmo_hit || fifo_late
                                  || sel_fault);
    assign tail_end = in_xfer && sector_end
                      && (state_reg == disk_err_pkg::ST_TAIL || verify_mismatch);

    always_ff @(posedge clk) begin
        if (rst || start_fn || state_reg == disk_err_pkg::ST_IDLE) begin
            xfer_cnt_reg <= 32'h0000_0000;
        end else begin
            xfer_cnt_reg <= xfer_cnt_reg + 32'h0000_0001;
        end
    end

    // sequence: start -> transfer -> (verify tail) -> idle
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= disk_err_pkg::ST_IDLE;
        end else if (clear_fn) begin
            state_reg <= disk_err_pkg::ST_IDLE;
        end else if (start_fn) begin
            state_reg <= disk_err_pkg::ST_XFER;
        end else begin
            unique case (state_reg)
                disk_err_pkg::ST_IDLE: state_reg <= disk_err_pkg::ST_IDLE;
                disk_err_pkg::ST_XFER: begin
                    if (kill_now || tail_end || xfer_complete) begin
                        state_reg <= disk_err_pkg::ST_IDLE;
                    end else if (verify_mismatch) begin
                        state_reg <= disk_err_pkg::ST_TAIL;
                    end
                end
                disk_err_pkg::ST_TAIL: begin
                    if (kill_now || tail_end || xfer_complete) begin
                        state_reg <= disk_err_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= disk_err_pkg::ST_IDLE;
            endcase
        end
    end

    // start clears errors; clear clears errors
    // cylinder error; surface error; verify error
    always_ff @(posedge clk) begin
        if (rst || start_fn || clear_fn) begin
            err_cyl_reg <= 1'b0;
            err_surf_reg <= 1'b0;
            err_ver_reg <= 1'b0;
            err_tmo_reg <= 1'b0;
            err_late_reg <= 1'b0;
        end else begin
            err_cyl_reg <= err_cyl_reg | (in_xfer && cyl_mismatch);
            err_surf_reg <= err_surf_reg | (in_xfer && surf_mismatch);
            err_ver_reg <= err_ver_reg | tail_end;
            err_tmo_reg <= err_tmo_reg | tmo_hit;
            err_late_reg <= err_late_reg | (in_xfer && fifo_late);
        end
    end

    // drive fault ends transfer with done; busy and done flags
    always_ff @(posedge clk) begin
        if (rst || clear_fn) begin
            xfer_busy <= 1'b0;
            xfer_done <= 1'b0;
            abort_xfer <= clear_fn && !rst && state_reg != disk_err_pkg::ST_IDLE;
        end else if (start_fn) begin
            xfer_busy <= 1'b1;
            xfer_done <= 1'b0;
            abort_xfer <= 1'b0;
        end else begin
            if (kill_now || tail_end || (in_xfer && xfer_complete)) begin
                xfer_busy <= 1'b0;
                xfer_done <= 1'b1;
            end
            abort_xfer <= kill_now;
        end
    end

    // ==========================================================
    // status words
    // ==========================================================
    logic [15:0] cs_host, ds_host;
    logic sel_drv_err;

    // drive word; fault placement depends on the variant
    always_comb begin
        ds_host = 16'h0000;
        ds_host[`DS_RELEASED] = s_rel[sel_reg];
        ds_host[`DS_RESERVED] = s_res[sel_reg];
        ds_host[`DS_READY] = s_rdy[sel_reg];
        ds_host[`DS_BUSY] = s_busy[sel_reg];
        ds_host[`DS_WPROT] = s_wp[sel_reg];
        ds_host[`DS_ILL_ADDR] = ill_addr_reg[sel_reg];
        ds_host[`DS_ILL_CMD] = ill_cmd_reg[sel_reg];
        if (MULTIFUNCTION != 0) begin
            ds_host[`DS_FAULT_HI] = sel_fault;
        end else begin
            for (int b = `DS_FAULT_LO; b <= `DS_FAULT_HI; b++) begin
                ds_host[b] = sel_fault;
            end
        end
        ds_host[`DS_ERROR] = ill_addr_reg[sel_reg] | ill_cmd_reg[sel_reg] | sel_fault;
    end

    assign sel_drv_err = ds_host[`DS_ERROR];

    always_comb begin
        cs_host = 16'h0000;
        cs_host[`CS_DONE] = xfer_done;
        cs_host[`CS_CYL] = err_cyl_reg;
        cs_host[`CS_SURF] = err_surf_reg;
        cs_host[`CS_VERIFY] = err_ver_reg;
        cs_host[`CS_TIMEOUT] = err_tmo_reg;
        cs_host[`CS_LATE] = err_late_reg;
        cs_host[`CS_ERROR] = err_cyl_reg | err_surf_reg | err_ver_reg | err_tmo_reg
                             | err_late_reg | sel_drv_err;
    end

    // host bit order on read; drive word for selected drive
    always_ff @(posedge clk) begin
        if (rst) begin
            status_data <= `STATUS_RESET;
            status_valid <= 1'b0;
        end else begin
            status_valid <= input_from_buffer_a | input_from_buffer_b;
            if (input_from_buffer_a) begin
                status_data <= to_acc(cs_host);
            end else if (input_from_buffer_b) begin
                status_data <= to_acc(ds_host);
            end
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    property p_cyl;
        @(posedge clk) disable iff (rst)
        (in_xfer && cyl_mismatch) |=> (err_cyl_reg && abort_xfer && xfer_done);
    endproperty
    a_cyl: assert property (p_cyl) else $error("cylinder error not flagged");

    property p_surf;
        @(posedge clk) disable iff (rst)
        (in_xfer && surf_mismatch) |=> (err_surf_reg && state_reg == disk_err_pkg::ST_IDLE);
    endproperty
    a_surf: assert property (p_surf) else $error("surface error not flagged");

    property p_verify;
        @(posedge clk) disable iff (rst)
        (in_xfer && verify_mismatch && !sector_end && !kill_now && !xfer_complete)
        |=> (state_reg == disk_err_pkg::ST_TAIL && !err_ver_reg);
    endproperty
    a_verify: assert property (p_verify) else $error("verify did not wait for sector end");

    property p_tmo;
        @(posedge clk) disable iff (rst)
        tmo_hit |=> (err_tmo_reg && abort_xfer);
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout not flagged");

    property p_late;
        @(posedge clk) disable iff (rst)
        (in_xfer && fifo_late) |=> (err_late_reg && !xfer_busy);
    endproperty
    a_late: assert property (p_late) else $error("data late not flagged");

    property p_sum;
        @(posedge clk) disable iff (rst)
        input_from_buffer_a |=> (status_data[15-`CS_ERROR] == $past(cs_host[`CS_CYL]
            | cs_host[`CS_SURF] | cs_host[`CS_VERIFY] | cs_host[`CS_TIMEOUT]
            | cs_host[`CS_LATE] | sel_drv_err));
    endproperty
    a_sum: assert property (p_sum) else $error("summary error bit wrong");

    property p_zero;
        @(posedge clk) disable iff (rst)
        input_from_buffer_b && !input_from_buffer_a
        |=> (status_data[13] | status_data[10] | status_data[8] | status_data[2]
             | status_data[1]) == 1'b0;
    endproperty
    a_zero: assert property (p_zero) else $error("unused drive bit set");

    property p_recal;
        @(posedge clk) disable iff (rst)
        (seek_issue && seek_cyl > MAX_CYL)
        |=> (recal_req[$past(sel_reg)] && ill_addr_reg[$past(sel_reg)]);
    endproperty
    a_recal: assert property (p_recal) else $error("no recalibrate after bad cylinder");

    property p_fclr;
        @(posedge clk) disable iff (rst)
        $rose(s_flt[0]) |=> fault_clear_req[0];
    endproperty
    a_fclr: assert property (p_fclr) else $error("no fault clear sent");

    property p_clear;
        @(posedge clk) disable iff (rst)
        clear_fn |=> (!xfer_busy && !xfer_done && !err_tmo_reg && !err_cyl_reg
                      && state_reg == disk_err_pkg::ST_IDLE);
    endproperty
    a_clear: assert property (p_clear) else $error("clear left state behind");

endmodule

/* verif/drive_bank_model.sv */
// behavioural bank of disk drives behind the error/status block
// assumes the bench sets pin levels by hierarchy; the bank answers recal and fault-clear
module drive_bank_model #(
    parameter int N = 4
) (
    input wire logic clk,
    input wire logic [N-1:0] recal_req,
    input wire logic [N-1:0] fault_clear_req,
    input wire logic [N-1:0] host_recal,
    output logic [N-1:0] drv_released,
    output logic [N-1:0] drv_reserved,
    output logic [N-1:0] drv_ready,
    output logic [N-1:0] drv_busy,
    output logic [N-1:0] drv_wprot,
    output logic [N-1:0] drv_fault,
    output logic [N-1:0] drv_seek_err,
    output logic [N-1:0] drv_seek_done
);
    timeunit 1ns;
    timeprecision 100ps;
    int fcnt [N];
    int rcnt [N];
    // ====================================
    // drive reactions
    // ====================================
    // all pins idle low; the bench raises them per scenario
    initial begin
        {drv_released, drv_reserved, drv_ready, drv_busy} = '0;
        {drv_wprot, drv_fault, drv_seek_err, drv_seek_done} = '0;
        fcnt = '{default: 0};
        rcnt = '{default: 0};
    end
    // fault clears late so it can still be read; recal keeps the drive busy 11 cycles
    always @(posedge clk) begin
        for (int d = 0; d < N; d++) begin
            if (fcnt[d] == 1) drv_fault[d] <= 1'b0;
            if (fault_clear_req[d]) fcnt[d] <= 20;
            else if (fcnt[d] != 0) fcnt[d] <= fcnt[d] - 1;
            if (rcnt[d] == 6) begin
                drv_busy[d] <= 1'b0;
                drv_seek_err[d] <= 1'b0;
                drv_seek_done[d] <= 1'b1;
            end
            if (rcnt[d] == 1) drv_seek_done[d] <= 1'b0;
            if (recal_req[d] || host_recal[d]) begin
                rcnt[d] <= 16;
                drv_busy[d] <= 1'b1;
            end else if (rcnt[d] != 0) begin
                rcnt[d] <= rcnt[d] - 1;
            end
        end
    end
endmodule

/* verif/disk_ctrl_error_status_test.sv */
// self-checking bench for the disk error/status block
// assumes a drive bank model on the pins; inputs change on the falling edge
module disk_ctrl_error_status_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] MAX_CYL = 16'h0332;
    logic clk = 0, rst = 1, rd_a = 0, rd_b = 0, sel = 0, start_fn = 0, clear_fn = 0;
    logic xfer_complete = 0, sector_end = 0, cyl_mm = 0, surf_mm = 0, ver_mm = 0;
    logic fifo_late = 0, seek_issue = 0, write_issue = 0, h_recal = 0;
    logic [15:0] bus_in = 16'h0000, seek_cyl = 16'h0000, status_data;
    logic status_valid, xfer_busy, xfer_done, abort_xfer, seen_abort;
    logic [3:0] recal_req, fc_req, dds, rel, res, rdy, bsy, wp, flt, serr, sdone;
    logic [3:0] recal_seen, fc_seen, dds_seen;
    int bad_count = 0, n_tests = 0;
    disk_err_status #(.NUM_DRIVES(4), .MULTIFUNCTION(0), .MAX_CYL(MAX_CYL),
        .XFER_TIMEOUT_CYC(50), .SEEK_TIMEOUT_CYC(40)) disk_err_status_i (
        .clk(clk), .rst(rst), .input_from_buffer_a(rd_a), .input_from_buffer_b(rd_b),
        .output_to_buffer_a(sel), .bus_in(bus_in), .start_fn(start_fn),
        .clear_fn(clear_fn), .xfer_complete(xfer_complete), .sector_end(sector_end),
        .cyl_mismatch(cyl_mm), .surf_mismatch(surf_mm), .verify_mismatch(ver_mm),
        .fifo_late(fifo_late), .seek_issue(seek_issue), .seek_cyl(seek_cyl),
        .write_issue(write_issue), .drv_released(rel), .drv_reserved(res),
        .drv_ready(rdy), .drv_busy(bsy), .drv_wprot(wp), .drv_fault(flt),
        .drv_seek_err(serr), .drv_seek_done(sdone), .status_data(status_data),
        .status_valid(status_valid), .xfer_busy(xfer_busy), .xfer_done(xfer_done),
        .abort_xfer(abort_xfer), .recal_req(recal_req), .fault_clear_req(fc_req),
        .drive_done_set(dds));
    drive_bank_model #(.N(4)) drive_bank_model_i (
        .clk(clk), .recal_req(recal_req), .fault_clear_req(fc_req),
        .host_recal({3'b000, h_recal}),
        .drv_released(rel), .drv_reserved(res), .drv_ready(rdy), .drv_busy(bsy),
        .drv_wprot(wp), .drv_fault(flt), .drv_seek_err(serr), .drv_seek_done(sdone));
    // ====================================
    // clock, pulse capture, watchdog
    // ====================================
    // 40 MHz clock
    always #12.5 clk = ~clk;
    // one-cycle pulses are caught here so scenarios need not hit the exact edge
    always @(posedge clk) begin
        seen_abort |= abort_xfer;
        recal_seen |= recal_req;
        fc_seen |= fc_req;
        dds_seen |= dds;
    end
    // whole run needs well under 1000 cycles
    initial begin
        #(25 * 3000);
        bad_count++;
        wrap_up();
    end
    // ====================================
    // shared tasks
    // ====================================
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic arm();
        seen_abort = 0;
        {recal_seen, fc_seen, dds_seen} = '0;
    endtask
    task automatic check1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // strobe one read; the answer stands one cycle later
    task automatic rd(input logic drive_word, input logic [15:0] exp);
        if (drive_word) rd_b = 1'b1;
        else rd_a = 1'b1;
        @(negedge clk);
        rd_a = 1'b0;
        rd_b = 1'b0;
        check1(status_valid, 1'b1);
        check16(status_data, exp);
    endtask
    task automatic pick(input logic [15:0] d);
        bus_in = d;
        pulse(sel);
    endtask
    // ====================================
    // scenarios
    // ====================================
    task automatic s_abort();
        int codes [3] = '{10, 11, 14};
        foreach (codes[i]) begin
            arm();
            pulse(start_fn);
            case (codes[i])
                10: pulse(cyl_mm);
                11: pulse(surf_mm);
                default: pulse(fifo_late);
            endcase
            idle(2);
            check1(seen_abort, 1'b1);
            rd(0, 16'h4001 | (16'h8000 >> codes[i]));
            if (codes[i] == 10) pulse(h_recal);
        end
    endtask
    task automatic s_verify_and_timeout();
        arm();
        pulse(start_fn);
        pulse(ver_mm);
        idle(2);
        check1(xfer_done, 1'b0);
        pulse(sector_end);
        idle(1);
        check1(xfer_done, 1'b1);
        check1(seen_abort, 1'b0);
        rd(0, 16'h4009);
        pulse(start_fn);
        pulse(xfer_complete);
        rd(0, 16'h4000);
        arm();
        pulse(start_fn);
        idle(60);
        check1(seen_abort, 1'b1);
        rd(0, 16'h4005);
    endtask
    task automatic s_clear();
        pulse(clear_fn);
        rd(0, 16'h0000);
        arm();
        pulse(start_fn);
        idle(2);
        pulse(clear_fn);
        idle(1);
        check1(seen_abort, 1'b1);
        check1(xfer_busy, 1'b0);
        rd(0, 16'h0000);
    endtask
    task automatic s_drive_word();
        {drive_bank_model_i.drv_released[2], drive_bank_model_i.drv_reserved[2],
         drive_bank_model_i.drv_ready[2], drive_bank_model_i.drv_busy[2],
         drive_bank_model_i.drv_wprot[2]} = 5'h1f;
        pick(16'h0002);
        idle(4);
        rd(1, 16'hda00);
        pick(16'h0000);
        rd(1, 16'h0000);
        {drive_bank_model_i.drv_released[2], drive_bank_model_i.drv_reserved[2],
         drive_bank_model_i.drv_ready[2], drive_bank_model_i.drv_busy[2],
         drive_bank_model_i.drv_wprot[2]} = 5'h00;
    endtask
    task automatic s_fault();
        arm();
        pick(16'h0000);
        pulse(start_fn);
        drive_bank_model_i.drv_fault[0] = 1'b1;
        idle(5);
        check1(seen_abort, 1'b1);
        check1(xfer_done, 1'b1);
        check1(fc_seen[0], 1'b1);
        rd(1, 16'h0039);
        rd(0, 16'h4001);
        idle(30);
        rd(0, 16'h4000);
    endtask
    task automatic s_illegal();
        arm();
        pulse(clear_fn);
        pick(16'h0003);
        seek_cyl = MAX_CYL + 16'h0001;
        pulse(seek_issue);
        idle(4);
        check1(recal_seen[3], 1'b1);
        idle(26);
        rd(1, 16'h0081);
        arm();
        pulse(clear_fn);
        seek_cyl = 16'h0010;
        pulse(seek_issue);
        idle(30);
        check1(recal_seen[3], 1'b0);
        idle(40);
        check1(recal_seen[3], 1'b1);
        rd(1, 16'h0081);
        pulse(clear_fn);
        drive_bank_model_i.drv_wprot[3] = 1'b1;
        idle(4);
        pulse(write_issue);
        idle(4);
        rd(1, 16'h0241);
        pulse(clear_fn);
        drive_bank_model_i.drv_wprot[3] = 1'b0;
        drive_bank_model_i.drv_busy[3] = 1'b1;
        idle(4);
        pulse(seek_issue);
        idle(2);
        rd(1, 16'h0841);
        drive_bank_model_i.drv_busy[3] = 1'b0;
    endtask
    task automatic s_seek_err();
        arm();
        drive_bank_model_i.drv_seek_err[0] = 1'b1;
        idle(6);
        check1(recal_seen[0], 1'b1);
        check1(dds_seen[0], 1'b1);
    endtask
    // ====================================
    // run
    // ====================================
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // reset for 8 cycles, then each scenario in turn
    initial begin
        arm();
        idle(8);
        rst = 1'b0;
        rd(0, 16'h0000);
        rd(1, 16'h0000);
        s_abort();
        s_verify_and_timeout();
        s_clear();
        s_drive_word();
        s_fault();
        s_illegal();
        s_seek_err();
        wrap_up();
    end
endmodule
